//--- eipc_cfg.svh
/*
 * constants for the emulation interrupt/protect control block:
 * field positions, opcode codes, micro entry addresses, reset values.
 * assumes instruction bit 0 is the msb of a 16-bit word (bit i at [15-i]).
 */
`ifndef EIPC_CFG_SVH
`define EIPC_CFG_SVH

`define EIPC_OP_STORAGE 4'h0
`define EIPC_SUB_SKIP_A 4'h1
`define EIPC_SUB_SKIP_B 4'h0
`define EIPC_SUB_SKIP_C 4'h6
`define EIPC_SUB_SE_A 4'h2
`define EIPC_SUB_SE_B 4'h3
`define EIPC_SUB_ENH_A 4'h4
`define EIPC_SUB_ENH_B 4'h5
`define EIPC_SUB_INTR 4'he
`define EIPC_SUB_INTERREG 4'h8
`define EIPC_SUB_EXTERNAL 4'hf
`define EIPC_DELTA_ALL_ONES 16'hffff
`define EIPC_UADDR_MICRO_INH 8'hbc
`define EIPC_UADDR_MACRO_INH 8'hbe
`define EIPC_UADDR_MICRO_RUN 8'hbd
`define EIPC_UADDR_MACRO_RUN 8'hbf
`define EIPC_PRIME_REL_BIT 0
`define EIPC_RST_PRE_ENABLE 1'b0
`define EIPC_RST_INT_ENABLE 1'b0
`define EIPC_RST_CLEAR_HALT 1'b0
`define EIPC_RST_HALT_BLOCK_N 1'b1

`endif

//--- eipc_ctrl.sv
/*
 * miscellaneous control of the emulation transform: delta translation,
 * protect violation, deferred interrupt enable, interrupt entry address,
 * destination strobe timing and halt blocking.
 * assumes microsequencer strobes are single-cycle pulses on sys_clk_i;
 * the protect switch and memory resume come from pins and are synchronised.
 */
`timescale 1ns/1ps
`include "eipc_cfg.svh"

// Summary of operation
// (RULE1) storage sub-opcode 0xxx or enhanced r=0: delta is eight zeros, bits 8-15
// (RULE2) sub-opcode 1xxx, 2, 3 or enhanced relative: low byte sign extended
// (RULE3) skip sub-opcodes: twelve zeros then bits 12-15
// (RULE4) sub-opcode E: seven zeros, a one, then bits 8-15
// (RULE5) inter-register (sub-opcode 1000): translator off, output all ones
// (RULE6) translation active only with decimal correct and override clear
// (RULE7) relative flag comes from prime register bit 0 (the msb)
// (RULE8) unprotected privileged instruction with protect switch set is a violation
// (RULE9) protected instruction right after unprotected one is a violation
// (RULE10) unprotected miscellaneous instruction with switch set is a violation
// (RULE11) protected-location writes are caught by memory interface, not here
// (RULE12) enable-interrupt emulation sets the pre-enable bit
// (RULE13) plain next instruction: strobe interrupt enable at next read-next
// (RULE14) storage, or enhanced other than type 2 skip, next: enable after its increment-P
// (RULE15) enable set clears the pre-enable bit
// (RULE16) interrupt entry BC micro or BE macro; inhibit takes precedence
// (RULE17) real non-inhibit interrupt: entry BD micro or BF macro
// (RULE18) destination strobe at T4, or resume trailing edge in transform-next
// (RULE19) macro go sets the clear-halt flag
// (RULE20) step mode transform-next clears the clear-halt flag
// (RULE21) halt block driven low on transform-next of memory ref or enhanced
// (RULE22) halt block returns high on increment-P and master clear
// (RULE23) master clear also clears the pre-enable bit
module eipc_ctrl
	import eipc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// instruction fields
	input wire logic [15:0] instr_i,
	input wire logic [7:0] instruction_prime_reg_i,
	input wire logic enhanced_i,
	input wire logic skip_type2_i,
	input wire logic misc_instr_i,
	input wire logic instr_protected_i,
	input wire logic interreg_dest_mem_i,
	// status mode bits
	input wire logic decimal_correct_enable_i,
	input wire logic file_select_override_i,
	input wire logic interrupt_kind_select_i,
	input wire logic step_mode_i,
	// microsequencer strobes
	input wire logic read_next_cycle_i,
	input wire logic transform_next_op_i,
	input wire logic increment_p_i,
	input wire logic enable_interrupt_instr_i,
	input wire logic inhibit_interrupt_instr_i,
	input wire logic macro_go_i,
	input wire logic interrupt_transform_i,
	input wire logic false_interrupt_i,
	input wire logic phase_t4_i,
	// pins
	input wire logic protect_switch_i,
	input wire logic mem_resume_i,
	// outputs
	output logic [15:0] delta_o,
	output logic protect_violation_o,
	output logic interrupt_pre_enable_bit_o,
	output logic interrupt_enable_bit_o,
	output logic set_interrupt_enable_strobe_o,
	output logic [7:0] interrupt_uaddr_o,
	output logic dest_strobe_o,
	output logic transform_strobe_delay_o,
	output logic clear_halt_flag_o,
	output logic halt_block_n_o
);
	// synchronised pin levels
	logic prot_sw;
	logic resume_s;
	logic resume_d_reg;

	eipc_sync2 u_sync_prot (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(protect_switch_i),
		.q_o(prot_sw)
	);

	eipc_sync2 u_sync_res (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(mem_resume_i),
		.q_o(resume_s)
	);

	// instruction decode; bit i of the word is instr_i[15-i]
	wire [3:0] op_f = instr_i[15:12];
	wire [3:0] sub_opcode_field = instr_i[11:8];
	wire [7:0] low_byte = instr_i[7:0];
	wire storage = (op_f == `EIPC_OP_STORAGE);
	// (RULE7) relative flag source
	wire rel_flag = instruction_prime_reg_i[7 - `EIPC_PRIME_REL_BIT];
	wire enh_form = storage && ((sub_opcode_field == `EIPC_SUB_ENH_A)
		|| (sub_opcode_field == `EIPC_SUB_ENH_B));
	wire interreg = storage && (sub_opcode_field == `EIPC_SUB_INTERREG);
	wire is_skip = storage && ((sub_opcode_field == `EIPC_SUB_SKIP_A)
		|| (sub_opcode_field == `EIPC_SUB_SKIP_B) || (sub_opcode_field == `EIPC_SUB_SKIP_C));
	wire is_intr = storage && (sub_opcode_field == `EIPC_SUB_INTR);
	wire se_form = storage && ((sub_opcode_field[3] && !interreg && !is_intr)
		|| (sub_opcode_field == `EIPC_SUB_SE_A) || (sub_opcode_field == `EIPC_SUB_SE_B)
		|| (enh_form && rel_flag));
	// (RULE6) translator enable
	wire xlate_en = !decimal_correct_enable_i && !file_select_override_i;

	// selection: skip and interrupt forms outrank the generic bands
	eipc_delta_sel_t dsel;
	always_comb begin
		if (interreg) begin
			dsel = EIPC_D_ONES;
		end else if (is_intr) begin
			dsel = EIPC_D_INTR;
		end else if (is_skip) begin
			dsel = EIPC_D_SKIP;
		end else if (se_form) begin
			dsel = EIPC_D_SIGNEXT;
		end else begin
			dsel = EIPC_D_ZERO8;
		end
	end

	logic [15:0] delta_next;
	always_comb begin
		case (dsel)
			// (RULE1) zero upper byte
			EIPC_D_ZERO8: delta_next = {8'h00, low_byte};
			// (RULE2) sign extend
			EIPC_D_SIGNEXT: delta_next = {{8{low_byte[7]}}, low_byte};
			// (RULE3) skip count
			EIPC_D_SKIP: delta_next = {12'h000, instr_i[3:0]};
			// (RULE4) interrupt form
			EIPC_D_INTR: delta_next = {8'h01, low_byte};
			// (RULE5) inter-register ones
			EIPC_D_ONES: delta_next = `EIPC_DELTA_ALL_ONES;
			default: delta_next = `EIPC_DELTA_ALL_ONES;
		endcase
		// translator disabled leaves selectors at all ones
		if (!xlate_en) begin
			delta_next = `EIPC_DELTA_ALL_ONES;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			delta_o <= `EIPC_DELTA_ALL_ONES;
		end else begin
			delta_o <= delta_next;
		end
	end

	// protect checks sampled at transform-next; memory writes are not seen here
	wire privileged = enable_interrupt_instr_i || inhibit_interrupt_instr_i
		|| interreg_dest_mem_i || (storage && (sub_opcode_field == `EIPC_SUB_EXTERNAL));
	logic last_unprot_reg;
	// (RULE8) privileged unprotected
	wire viol_priv = !instr_protected_i && prot_sw && privileged;
	// (RULE9) protected after unprotected
	wire viol_seq = instr_protected_i && last_unprot_reg;
	// (RULE10) misc unprotected
	wire viol_misc = !instr_protected_i && prot_sw && misc_instr_i;
	wire viol_any = transform_next_op_i && (viol_priv || viol_seq || viol_misc);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_unprot_reg <= 1'b0;
			protect_violation_o <= 1'b0;
		end else begin
			if (transform_next_op_i) begin
				last_unprot_reg <= !instr_protected_i;
			end
			protect_violation_o <= viol_any;
		end
	end

	// deferred interrupt enable
	eipc_ie_state_t ie_reg;
	eipc_ie_state_t ie_next;
	wire deferred_kind = storage || (enhanced_i && !skip_type2_i);
	wire set_ie_now;
	always_comb begin
		ie_next = ie_reg;
		case (ie_reg)
			EIPC_IE_IDLE: begin
				if (enable_interrupt_instr_i) begin
					ie_next = EIPC_IE_WAIT_READ;
				end
			end
			EIPC_IE_WAIT_READ: begin
				// classification at the transform of the following instruction
				if (transform_next_op_i && deferred_kind) begin
					ie_next = EIPC_IE_WAIT_INCP;
				end else if (read_next_cycle_i) begin
					ie_next = EIPC_IE_IDLE;
				end
			end
			EIPC_IE_WAIT_INCP: begin
				if (increment_p_i) begin
					ie_next = EIPC_IE_IDLE;
				end
			end
			default: ie_next = EIPC_IE_IDLE;
		endcase
	end
	// (RULE13) strobe at next read-next; (RULE14) or at increment-P
	assign set_ie_now = ((ie_reg == EIPC_IE_WAIT_READ) && read_next_cycle_i
		&& !(transform_next_op_i && deferred_kind))
		|| ((ie_reg == EIPC_IE_WAIT_INCP) && increment_p_i);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// (RULE23) master clear drops pre-enable
			ie_reg <= EIPC_IE_IDLE;
			interrupt_pre_enable_bit_o <= `EIPC_RST_PRE_ENABLE;
			interrupt_enable_bit_o <= `EIPC_RST_INT_ENABLE;
			set_interrupt_enable_strobe_o <= 1'b0;
		end else begin
			ie_reg <= ie_next;
			set_interrupt_enable_strobe_o <= set_ie_now;
			// (RULE12) set on enable-interrupt; (RULE15) cleared once enabled
			if (enable_interrupt_instr_i) begin
				interrupt_pre_enable_bit_o <= 1'b1;
			end else if (set_ie_now) begin
				interrupt_pre_enable_bit_o <= 1'b0;
			end
			// a pending enable outranks inhibit-interrupt
			if (set_ie_now) begin
				interrupt_enable_bit_o <= 1'b1;
			end else if (inhibit_interrupt_instr_i) begin
				interrupt_enable_bit_o <= 1'b0;
			end
		end
	end

	// interrupt entry addresses
	wire run_entry = !inhibit_interrupt_instr_i && !false_interrupt_i;
	wire [7:0] uaddr_sel;
	// (RULE16) inhibit entries; (RULE17) run entries
	assign uaddr_sel = run_entry
		? (interrupt_kind_select_i ? `EIPC_UADDR_MACRO_RUN : `EIPC_UADDR_MICRO_RUN)
		: (interrupt_kind_select_i ? `EIPC_UADDR_MACRO_INH : `EIPC_UADDR_MICRO_INH);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			interrupt_uaddr_o <= `EIPC_UADDR_MICRO_INH;
		end else if (interrupt_transform_i) begin
			interrupt_uaddr_o <= uaddr_sel;
		end
	end

	// destination strobe; resume edge found on the second sync flop only
	logic xt_active_reg;
	wire resume_fall = resume_d_reg && !resume_s;
	// (RULE18) strobe timing choice
	wire strobe_next = xt_active_reg ? resume_fall : (phase_t4_i && !transform_next_op_i);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			resume_d_reg <= 1'b0;
			xt_active_reg <= 1'b0;
			dest_strobe_o <= 1'b0;
			transform_strobe_delay_o <= 1'b0;
		end else begin
			resume_d_reg <= resume_s;
			if (transform_next_op_i) begin
				xt_active_reg <= 1'b1;
			end else if (resume_fall) begin
				xt_active_reg <= 1'b0;
			end
			dest_strobe_o <= strobe_next;
			transform_strobe_delay_o <= transform_next_op_i || (xt_active_reg && !resume_fall);
		end
	end

	// halt blocking in any mode; clear-halt flag cleared in step mode
	wire block_halt = transform_next_op_i && (storage || enhanced_i);
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clear_halt_flag_o <= `EIPC_RST_CLEAR_HALT;
			// (RULE22) master clear raises block
			halt_block_n_o <= `EIPC_RST_HALT_BLOCK_N;
		end else begin
			// (RULE19) go sets; (RULE20) step transform clears
			if (macro_go_i) begin
				clear_halt_flag_o <= 1'b1;
			end else if (step_mode_i && transform_next_op_i) begin
				clear_halt_flag_o <= 1'b0;
			end
			// (RULE21) block on decode; set wins over release
			if (block_halt) begin
				halt_block_n_o <= 1'b0;
			end else if (increment_p_i) begin
				halt_block_n_o <= 1'b1;
			end
		end
	end

	// checks
	property p_halt_block;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		block_halt |=> !halt_block_n_o;
	endproperty
	a_halt_block: assert property (p_halt_block) else $error("halt block not driven low"); // RULE21

	property p_halt_release;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(increment_p_i && !block_halt) |=> halt_block_n_o;
	endproperty
	a_halt_release: assert property (p_halt_release) else $error("halt block not released"); // RULE22

	property p_go_sets;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		macro_go_i |=> clear_halt_flag_o;
	endproperty
	a_go_sets: assert property (p_go_sets) else $error("go did not set clear-halt"); // RULE19

	property p_step_clears;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(step_mode_i && transform_next_op_i && !macro_go_i) |=> !clear_halt_flag_o;
	endproperty
	a_step_clears: assert property (p_step_clears) else $error("step did not clear"); // RULE20

	property p_pre_enable;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		enable_interrupt_instr_i |=> interrupt_pre_enable_bit_o;
	endproperty
	a_pre_enable: assert property (p_pre_enable) else $error("pre-enable not set"); // RULE12

	property p_pre_clear;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(interrupt_enable_bit_o) |-> !interrupt_pre_enable_bit_o || $past(enable_interrupt_instr_i);
	endproperty
	a_pre_clear: assert property (p_pre_clear) else $error("pre-enable left set"); // RULE15

	property p_interreg_ones;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		interreg |=> (delta_o == `EIPC_DELTA_ALL_ONES);
	endproperty
	a_interreg_ones: assert property (p_interreg_ones) else $error("inter-register delta wrong"); // RULE5

	property p_intr_delta;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(is_intr && xlate_en) |=> (delta_o == {8'h01, $past(low_byte)});
	endproperty
	a_intr_delta: assert property (p_intr_delta) else $error("interrupt delta wrong"); // RULE4

	property p_uaddr_run;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(interrupt_transform_i && run_entry && interrupt_kind_select_i)
			|=> (interrupt_uaddr_o == `EIPC_UADDR_MACRO_RUN);
	endproperty
	a_uaddr_run: assert property (p_uaddr_run) else $error("run entry address wrong"); // RULE17

endmodule : eipc_ctrl

//--- eipc_host_model.sv
/*
 * host microsequencer model: turns micro-op request bits, one per strobe, into strobes
 * and plays the memory resume pin.
 * assumes requests change just after sys_clk_i rises.
 */
`timescale 1ns/1ps
module eipc_host_model (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// requests
	input wire logic [7:0] uop_i,
	input wire logic resume_req_i,
	// strobes
	output logic read_next_cycle_o,
	output logic transform_next_op_o,
	output logic increment_p_o,
	output logic enable_interrupt_instr_o,
	output logic inhibit_interrupt_instr_o,
	output logic macro_go_o,
	output logic interrupt_transform_o,
	output logic phase_t4_o,
	// pin
	output logic mem_resume_o
);
	logic [1:0] resume_cnt_reg;

	assign read_next_cycle_o = uop_i[0];
	assign transform_next_op_o = uop_i[1];
	assign increment_p_o = uop_i[2];
	assign enable_interrupt_instr_o = uop_i[3];
	assign inhibit_interrupt_instr_o = uop_i[4];
	assign macro_go_o = uop_i[5];
	assign interrupt_transform_o = uop_i[6];
	assign phase_t4_o = uop_i[7];

	// resume held two cycles so its fall lands inside the transform
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			resume_cnt_reg <= 2'h0;
		else if (resume_req_i)
			resume_cnt_reg <= 2'h2;
		else if (resume_cnt_reg != 2'h0)
			resume_cnt_reg <= resume_cnt_reg - 2'h1;
	end
	assign mem_resume_o = (resume_cnt_reg != 2'h0);
endmodule : eipc_host_model

//--- eipc_pkg.sv
/*
 * types shared by the emulation interrupt/protect control block.
 * assumes the constants header is included by the files that need it.
 */
package eipc_pkg;

	typedef enum logic [2:0] {
		EIPC_D_ZERO8,
		EIPC_D_SIGNEXT,
		EIPC_D_SKIP,
		EIPC_D_INTR,
		EIPC_D_ONES
	} eipc_delta_sel_t;

	typedef enum logic [1:0] {
		EIPC_IE_IDLE,
		EIPC_IE_WAIT_READ,
		EIPC_IE_WAIT_INCP
	} eipc_ie_state_t;

endpackage : eipc_pkg

//--- eipc_sync2.sv
/*
 * two-flop synchroniser for one level.
 * assumes d_i comes from another clock domain or a pin.
 */
`timescale 1ns/1ps
module eipc_sync2 (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// level
	input wire logic d_i,
	output logic q_o
);
	logic meta_reg;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule : eipc_sync2

//--- testbench.sv
/*
 * self-checking bench for eipc_ctrl with the host model on its strobes.
 * assumes a 25 MHz clock and async active-low master clear.
 */
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] U_RN = 8'h01, U_TN = 8'h02, U_INCP = 8'h04, U_ENA = 8'h08;
	localparam logic [7:0] U_INH = 8'h10, U_GO = 8'h20, U_INT = 8'h40, U_T4 = 8'h80;
	logic sys_clk_i, rst_n_i, enh, sk2, misc, prot, irm, dce, fso, kind, step, fint, psw, rreq;
	logic [15:0] instr, delta;
	logic [7:0] prime, uop, uaddr;
	logic rn, tn, incp, enable_interrupt_instr, inhibit_interrupt_instr, go, itr, t4, mres;
	logic viol, pre, ien, sie, dst, tsd, chf, hbn;
	int bad_count, check_count;

	eipc_host_model host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .uop_i(uop),
		.resume_req_i(rreq), .read_next_cycle_o(rn), .transform_next_op_o(tn),
		.increment_p_o(incp), .enable_interrupt_instr_o(enable_interrupt_instr), .inhibit_interrupt_instr_o(inhibit_interrupt_instr),
		.macro_go_o(go), .interrupt_transform_o(itr), .phase_t4_o(t4), .mem_resume_o(mres));

	eipc_ctrl dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .instr_i(instr),
		.instruction_prime_reg_i(prime), .enhanced_i(enh), .skip_type2_i(sk2),
		.misc_instr_i(misc), .instr_protected_i(prot), .interreg_dest_mem_i(irm),
		.decimal_correct_enable_i(dce), .file_select_override_i(fso),
		.interrupt_kind_select_i(kind), .step_mode_i(step), .read_next_cycle_i(rn),
		.transform_next_op_i(tn), .increment_p_i(incp), .enable_interrupt_instr_i(enable_interrupt_instr),
		.inhibit_interrupt_instr_i(inhibit_interrupt_instr), .macro_go_i(go), .interrupt_transform_i(itr),
		.false_interrupt_i(fint), .phase_t4_i(t4), .protect_switch_i(psw),
		.mem_resume_i(mres), .delta_o(delta), .protect_violation_o(viol),
		.interrupt_pre_enable_bit_o(pre), .interrupt_enable_bit_o(ien),
		.set_interrupt_enable_strobe_o(sie), .interrupt_uaddr_o(uaddr),
		.dest_strobe_o(dst), .transform_strobe_delay_o(tsd), .clear_halt_flag_o(chf),
		.halt_block_n_o(hbn));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkb(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask : chkb

	task automatic pulse(input logic [7:0] v);
		@(posedge sys_clk_i);
		uop <= v;
		@(posedge sys_clk_i);
		uop <= 8'h00;
		#1;
	endtask : pulse

	task automatic stop_test();
		$display("checks=%0d bad=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	task automatic t_delta();
		logic [41:0] tab [13] = '{{16'h0785, 8'h00, 2'b00, 16'h0085},
			{16'h0485, 8'h00, 2'b00, 16'h0085}, {16'h0485, 8'h80, 2'b00, 16'hff85},
			{16'h0285, 8'h00, 2'b00, 16'hff85}, {16'h0345, 8'h00, 2'b00, 16'h0045},
			{16'h0985, 8'h00, 2'b00, 16'hff85}, {16'h0085, 8'h00, 2'b00, 16'h0005},
			{16'h0185, 8'h00, 2'b00, 16'h0005}, {16'h0685, 8'h00, 2'b00, 16'h0005},
			{16'h0e85, 8'h00, 2'b00, 16'h0185}, {16'h0885, 8'h00, 2'b00, 16'hffff},
			{16'h0785, 8'h00, 2'b10, 16'hffff}, {16'h0785, 8'h00, 2'b01, 16'hffff}};
		@(posedge sys_clk_i);
		enh <= 1'b1;
		foreach (tab[i]) begin
			@(posedge sys_clk_i);
			{instr, prime, dce, fso} <= tab[i][41:16];
			@(posedge sys_clk_i);
			#1;
			chk(delta, tab[i][15:0]);
		end
		@(posedge sys_clk_i);
		{enh, dce, fso} <= 3'h0;
		$display("done delta");
	endtask : t_delta

	task automatic t_ie();
		@(posedge sys_clk_i);
		instr <= 16'h4000;
		pulse(U_ENA);
		chkb(pre, 1'b1);
		pulse(U_RN);
		chkb(sie, 1'b1);
		chkb(ien, 1'b1);
		chkb(pre, 1'b0);
		pulse(U_INH);
		chkb(ien, 1'b0);
		@(posedge sys_clk_i);
		instr <= 16'h0200;
		pulse(U_ENA);
		pulse(U_TN);
		pulse(U_RN);
		chkb(sie, 1'b0);
		chkb(ien, 1'b0);
		pulse(U_INCP);
		chkb(ien, 1'b1);
		@(posedge sys_clk_i);
		#1;
		chkb(pre, 1'b0);
		pulse(U_INH);
		// enhanced type 2 skip enables at once, other enhanced waits
		@(posedge sys_clk_i);
		{enh, sk2} <= 2'b11;
		instr <= 16'h4000;
		pulse(U_ENA);
		pulse(U_TN);
		pulse(U_RN);
		chkb(sie, 1'b1);
		@(posedge sys_clk_i);
		sk2 <= 1'b0;
		pulse(U_INH);
		pulse(U_ENA);
		pulse(U_TN);
		pulse(U_RN);
		chkb(ien, 1'b0);
		pulse(U_INCP);
		chkb(ien, 1'b1);
		// one memory resume after the transforms above ends the held strobe
		@(posedge sys_clk_i);
		{enh, rreq} <= 2'b01;
		@(posedge sys_clk_i);
		rreq <= 1'b0;
		pulse(U_INH);
		$display("done interrupt enable");
	endtask : t_ie

	task automatic t_misc();
		int n;
		logic [19:0] tab [5] = '{{16'h0800, 4'b0011}, {16'h4000, 4'b1001},
			{16'h4000, 4'b0101}, {16'h4000, 4'b0100}, {16'h0f00, 4'b0001}};
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk_i);
			kind <= k[1];
			fint <= k[0];
			pulse(U_INT);
			chk({8'h00, uaddr}, {8'h00, k[0] ? (k[1] ? 8'hbe : 8'hbc)
				: (k[1] ? 8'hbf : 8'hbd)});
		end
		@(posedge sys_clk_i);
		{kind, fint} <= 2'b10;
		pulse(U_INT | U_INH);
		chk({8'h00, uaddr}, 16'h00be);
		pulse(U_T4);
		chkb(dst, 1'b1);
		pulse(U_TN | U_T4);
		chkb(dst, 1'b0);
		chkb(tsd, 1'b1);
		@(posedge sys_clk_i);
		rreq <= 1'b1;
		@(posedge sys_clk_i);
		rreq <= 1'b0;
		n = 0;
		repeat (8) begin
			@(posedge sys_clk_i);
			#1;
			if (dst === 1'b1)
				n++;
		end
		chk(n[15:0], 16'h0001);
		@(posedge sys_clk_i);
		psw <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		foreach (tab[i]) begin
			@(posedge sys_clk_i);
			{instr, misc, prot, irm} <= tab[i][19:1];
			pulse(U_TN);
			chkb(viol, tab[i][0]);
		end
		$display("done address strobe protect");
	endtask : t_misc

	task automatic t_halt();
		@(posedge sys_clk_i);
		step <= 1'b1;
		instr <= 16'h0200;
		pulse(U_GO);
		chkb(chf, 1'b1);
		pulse(U_TN);
		chkb(chf, 1'b0);
		chkb(hbn, 1'b0);
		pulse(U_INCP);
		chkb(hbn, 1'b1);
		pulse(U_ENA | U_TN);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		#1;
		chkb(pre, 1'b0);
		chkb(hbn, 1'b1);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		$display("done halt and clear");
	endtask : t_halt

	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	// the tests take about 150 cycles; this is over thirty times that
	initial begin
		#(40 * 5000);
		bad_count++;
		stop_test();
	end

	initial begin
		{enh, sk2, misc, prot, irm, dce, fso, kind, step, fint, psw, rreq} = 12'h000;
		instr = 16'h0000;
		prime = 8'h00;
		uop = 8'h00;
		rst_n_i = 1'b0;
		bad_count = 0;
		check_count = 0;
		repeat (20) @(posedge sys_clk_i);
		#1;
		chk(delta, 16'hffff);
		chk({8'h00, uaddr}, 16'h00bc);
		chkb(hbn, 1'b1);
		chkb(pre, 1'b0);
		chkb(chf, 1'b0);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_delta();
		t_ie();
		t_misc();
		t_halt();
		stop_test();
	end
endmodule : testbench
